// file: hdl/pcg_clock_generator.sv
// The implementer's own choice: the Avalon-MM register port.
`default_nettype none
`include "pcg_defs.svh"
module pcg_clock_generator (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ref_clk,
   input wire logic fixed_12m_clk,
   input wire logic pll_ext_reset_n,
   input wire logic [2:0] converter_ratio_select,
   input wire logic [9:0] pwm_prescale_value,
   output pcg_pkg::pcg_pll_ctrl_s pll_ctrl,
   output pcg_pkg::pcg_clocks_s clocks
);
   ////////////////////////////////////////////////////////////////////////////
   // Register bank
   logic [15:0] main_clock_divider, codec_clock_divider;
   logic [15:0] system_bus_clock_divider, peripheral_bus_clock_divider;
   logic [15:0] pll_input_divider, pll_feedback_divider, pll_output_divider;
   logic [15:0] pll_power_bypass_control, pll_test_control, clock_gate_enables;
   logic [15:0] status_word;
   logic bus_ack, wr_take;
   logic [15:0] wmask, next_rdata;

   // Two-cycle access: wait during the first, complete on the second
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign wr_take = avs_write && bus_ack;
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Ack toggles one cycle after a request appears
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         bus_ack <= 1'b0;
      else
         bus_ack <= (avs_read || avs_write) && !bus_ack;
   end

   // Merge a write into a register under byte enables
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data, input logic [15:0] m);
      merge = (old & ~m) | (data & m);
   endfunction

   // Software writes, taken at the edge where waitrequest is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_clock_divider <= `PCG_RST_MAIN;
         codec_clock_divider <= `PCG_RST_CODEC;
         system_bus_clock_divider <= `PCG_RST_SYS;
         peripheral_bus_clock_divider <= `PCG_RST_PERIPH;
         pll_input_divider <= `PCG_RST_NDIV;
         pll_feedback_divider <= `PCG_RST_MDIV;
         pll_output_divider <= `PCG_RST_ODIV;
         pll_power_bypass_control <= `PCG_RST_PDBP;
         pll_test_control <= `PCG_RST_TEST;
         clock_gate_enables <= `PCG_RST_GATE;
      end else if (wr_take) begin
         unique case (avs_address)
            `PCG_OFF_MAIN: main_clock_divider <= merge(main_clock_divider, avs_writedata[15:0], wmask & 16'h00FF);
            `PCG_OFF_CODEC: codec_clock_divider <= merge(codec_clock_divider, avs_writedata[15:0], wmask & 16'h01FF);
            `PCG_OFF_SYS: system_bus_clock_divider <= merge(system_bus_clock_divider, avs_writedata[15:0],
                                                           wmask & 16'h0003);
            `PCG_OFF_PERIPH: peripheral_bus_clock_divider <= merge(peripheral_bus_clock_divider,
                                                                   avs_writedata[15:0], wmask & 16'h0003);
            `PCG_OFF_NDIV: pll_input_divider <= merge(pll_input_divider, avs_writedata[15:0], wmask & 16'h001F);
            `PCG_OFF_MDIV: pll_feedback_divider <= merge(pll_feedback_divider, avs_writedata[15:0], wmask & 16'h01FF);
            `PCG_OFF_ODIV: pll_output_divider <= merge(pll_output_divider, avs_writedata[15:0], wmask & 16'h0003);
            `PCG_OFF_PDBP: pll_power_bypass_control <= merge(pll_power_bypass_control, avs_writedata[15:0],
                                                             wmask & 16'h0003);
            `PCG_OFF_TEST: pll_test_control <= merge(pll_test_control, avs_writedata[15:0], wmask & 16'h001F);
            `PCG_OFF_GATE: clock_gate_enables <= merge(clock_gate_enables, avs_writedata[15:0], wmask & 16'h001F);
            default: ;
         endcase
      end
   end

   // Read decode; unmapped addresses read zero
   always_comb begin
      unique case (avs_address)
         `PCG_OFF_MAIN: next_rdata = main_clock_divider;
         `PCG_OFF_CODEC: next_rdata = codec_clock_divider;
         `PCG_OFF_SYS: next_rdata = system_bus_clock_divider;
         `PCG_OFF_PERIPH: next_rdata = peripheral_bus_clock_divider;
         `PCG_OFF_NDIV: next_rdata = pll_input_divider;
         `PCG_OFF_MDIV: next_rdata = pll_feedback_divider;
         `PCG_OFF_ODIV: next_rdata = pll_output_divider;
         `PCG_OFF_PDBP: next_rdata = pll_power_bypass_control;
         `PCG_OFF_TEST: next_rdata = pll_test_control;
         `PCG_OFF_STATUS: next_rdata = status_word;
         `PCG_OFF_GATE: next_rdata = clock_gate_enables;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data captured in the waiting cycle, stands at the completing edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         avs_readdata <= 32'h00000000;
      else if (avs_read && !bus_ack)
         avs_readdata <= {16'h0000, next_rdata};
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL controls
   logic test_mode;
   assign test_mode = pll_test_control[`PCG_BIT_TEST_EN];

   // Register fields wired to the PLL macro
   always_comb begin
      pll_ctrl.input_ratio = pll_input_divider[4:0];
      pll_ctrl.feedback_ratio = pll_feedback_divider[8:0];
      pll_ctrl.input_ratio_eff = 6'(pll_input_divider[4:0]) + 6'(`PCG_PLL_RATIO_OFFSET);
      pll_ctrl.feedback_ratio_eff = 10'(pll_feedback_divider[8:0]) + 10'(`PCG_PLL_RATIO_OFFSET);
      pll_ctrl.pll_output_ratio = pll_output_divider[1:0];
      pll_ctrl.pll_bypass = pll_power_bypass_control[`PCG_BIT_BYPASS];
      pll_ctrl.pll_power_down = pll_power_bypass_control[`PCG_BIT_PDOWN];
      pll_ctrl.pll_reset = test_mode && !pll_ext_reset_n;
      pll_ctrl.pll_test_select = pll_test_control[2:1];
      pll_ctrl.pll_aux_output_one_disable = pll_test_control[`PCG_BIT_AUX1_DIS];
      pll_ctrl.pll_aux_output_two_disable = pll_test_control[`PCG_BIT_AUX2_DIS];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source ticks: core_clk stands for the PLL output
   logic ref_prev, fixed_prev, ref_tick, fixed_tick, src_tick;

   // Edge detect the synchronous reference and fixed 12 MHz levels
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev <= 1'b0;
         fixed_prev <= 1'b0;
      end else begin
         ref_prev <= ref_clk;
         fixed_prev <= fixed_12m_clk;
      end
   end
   assign ref_tick = ref_clk && !ref_prev;
   assign fixed_tick = fixed_12m_clk && !fixed_prev;
   assign src_tick = pll_ctrl.pll_bypass ? ref_tick : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Divider chain
   logic main_start, sys_start, periph_start;
   logic main_lvl, sys_lvl, periph_lvl, codec_lvl, conv_lvl, pwm_lvl;
   logic main_run, sys_run, periph_run, codec_run, conv_run, pwm_run;
   logic [2:0] sys_ratio, periph_ratio;
   logic [9:0] pwm_ratio;
   logic codec_en;
   logic sys_pass, periph_pass, sys_clk, periph_clk;

   // Select 00..11 means divide by 1, 2, 4 or 8
   assign sys_ratio = 3'((4'h1 << system_bus_clock_divider[1:0]) - 4'h1);
   assign periph_ratio = 3'((4'h1 << peripheral_bus_clock_divider[1:0]) - 4'h1);
   // PWM prescale floored so the count clock stays at or below 1 MHz
   assign pwm_ratio = (pwm_prescale_value < 10'(`PCG_PWM_MIN_RATIO)) ? 10'(`PCG_PWM_MIN_RATIO)
                      : pwm_prescale_value;
   assign codec_en = clock_gate_enables[`PCG_GATE_CODEC] && !codec_clock_divider[`PCG_BIT_CODEC_SEL];

   // Main clock from the PLL output, 8-bit ratio
   pcg_divider #(.W(8)) u_main (.core_clk(core_clk), .rst_n(rst_n), .tick(src_tick), .enable(1'b1),
      .ratio(main_clock_divider[7:0]), .clk_level(main_lvl), .period_start(main_start),
      .running(main_run));
   // System bus clock stepped by main period starts, so edges align
   pcg_divider #(.W(3)) u_sys (.core_clk(core_clk), .rst_n(rst_n), .tick(main_start), .enable(1'b1),
      .ratio(sys_ratio), .clk_level(sys_lvl), .period_start(sys_start), .running(sys_run));
   // Peripheral bus clock stepped by system bus period starts
   pcg_divider #(.W(3)) u_periph (.core_clk(core_clk), .rst_n(rst_n), .tick(sys_start), .enable(1'b1),
      .ratio(periph_ratio), .clk_level(periph_lvl), .period_start(periph_start), .running(periph_run));
   // Codec divided path from the PLL output
   pcg_divider #(.W(8)) u_codec (.core_clk(core_clk), .rst_n(rst_n), .tick(src_tick), .enable(codec_en),
      .ratio(codec_clock_divider[7:0]), .clk_level(codec_lvl), .period_start(), .running(codec_run));
   // Converter clock from the fixed 12 MHz, so never faster
   pcg_divider #(.W(3)) u_conv (.core_clk(core_clk), .rst_n(rst_n), .tick(fixed_tick), .enable(1'b1),
      .ratio(converter_ratio_select), .clk_level(conv_lvl), .period_start(), .running(conv_run));
   // PWM count clock from the fixed 12 MHz
   pcg_divider #(.W(10)) u_pwm (.core_clk(core_clk), .rst_n(rst_n), .tick(fixed_tick), .enable(1'b1),
      .ratio(pwm_ratio), .clk_level(pwm_lvl), .period_start(), .running(pwm_run));

   // Divide by one passes the main waveform, chosen at period start like a ratio
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         sys_pass <= 1'b0;
      else if (sys_start)
         sys_pass <= (sys_ratio == 3'h0);
   end
   // Same for the peripheral bus, passing the system bus waveform
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         periph_pass <= 1'b0;
      else if (periph_start)
         periph_pass <= (periph_ratio == 3'h0);
   end
   // Bus clocks after the pass-through; a lone divider would hold high at ratio zero
   assign sys_clk = sys_pass ? main_lvl : sys_lvl;
   assign periph_clk = periph_pass ? sys_clk : periph_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // Glitch-free gates: usb, codec fixed path, card, memory, dma
   logic [4:0] gate_src, gate_en, gate_run, gate_out;
   assign gate_src = {sys_clk, sys_clk, sys_clk, fixed_12m_clk, fixed_12m_clk};
   assign gate_en = {clock_gate_enables[`PCG_GATE_DMA], clock_gate_enables[`PCG_GATE_MEM],
                     clock_gate_enables[`PCG_GATE_CARD],
                     clock_gate_enables[`PCG_GATE_CODEC] && codec_clock_divider[`PCG_BIT_CODEC_SEL],
                     clock_gate_enables[`PCG_GATE_USB]};

   // Enable changes only while the source is low
   for (genvar g = 0; g < 5; g++) begin : g_gate
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            gate_run[g] <= 1'b0;
            gate_out[g] <= 1'b0;
         end else begin
            if (!gate_src[g])
               gate_run[g] <= gate_en[g];
            gate_out[g] <= gate_src[g] && (gate_src[g] ? gate_run[g] : gate_en[g]);
         end
      end
   end

   // Clock outputs
   always_comb begin
      clocks.main_clock = main_lvl;
      clocks.system_bus_clock = sys_clk;
      clocks.peripheral_bus_clock = periph_clk;
      clocks.codec_master_clock = codec_clock_divider[`PCG_BIT_CODEC_SEL] ? gate_out[1] : codec_lvl;
      clocks.usb_fixed_clock = gate_out[0];
      clocks.memory_controller_clock = gate_out[3];
      clocks.card_interface_clock = gate_out[2];
      clocks.dma_clock = gate_out[4];
      clocks.converter_clock = conv_lvl;
      clocks.pwm_count_clock = pwm_lvl;
   end

   // Running flags visible to software
   assign status_word = {5'h00, gate_run, pwm_run, conv_run, codec_run, periph_run, sys_run, main_run};

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_bus_wait: assert property ((avs_read || avs_write) && !bus_ack |-> avs_waitrequest)
      else $error("Request completed without a wait cycle");
   chk_pll_reset: assert property (!test_mode |-> !pll_ctrl.pll_reset)
      else $error("PLL reset raised outside test mode");
   chk_eff_ratio: assert property (pll_ctrl.input_ratio_eff == 6'(pll_input_divider[4:0]) + 6'h02)
      else $error("Effective input ratio is not field plus two");
   chk_bypass_src: assert property (pll_ctrl.pll_bypass && !ref_tick |-> !src_tick)
      else $error("Source ticked during bypass without reference edge");
   chk_sys_align: assert property (sys_start |-> main_start)
      else $error("System bus period not aligned to main clock");
   chk_periph_align: assert property (periph_start |-> sys_start && main_start)
      else $error("Peripheral period not aligned");
   chk_sys_ratio: assert property (system_bus_clock_divider[1:0] == 2'h3 |-> sys_ratio == 3'h7)
      else $error("System bus divide by eight wrong");
   chk_pwm_floor: assert property (pwm_ratio >= 10'h00B && pwm_ratio >= pwm_prescale_value)
      else $error("PWM ratio below floor");
   chk_gate_low: assert property (gate_run != $past(gate_run)
      |-> ($past(gate_src) & (gate_run ^ $past(gate_run))) == 5'h00)
      else $error("Gate enable changed while source high");
   chk_write_take: assert property (wr_take && avs_address == `PCG_OFF_GATE && avs_byteenable[0]
      |=> clock_gate_enables[4:0] == $past(avs_writedata[4:0]))
      else $error("Gate register write lost");
   chk_main_write: assert property (wr_take && avs_address == `PCG_OFF_MAIN && avs_byteenable[0]
      |=> main_clock_divider[7:0] == $past(avs_writedata[7:0]))
      else $error("Main divider write lost");
   chk_gate_read: assert property (avs_read && !avs_waitrequest && avs_address == `PCG_OFF_GATE
      |-> avs_readdata[15:0] == clock_gate_enables)
      else $error("Gate register read data wrong");
   chk_sys_div_one: assert property (sys_start && sys_ratio == 3'h0
      |=> clocks.system_bus_clock == clocks.main_clock)
      else $error("System bus clock not the main clock at divide by one");
   chk_periph_div_one: assert property (periph_start && periph_ratio == 3'h0
      |=> clocks.peripheral_bus_clock == clocks.system_bus_clock)
      else $error("Peripheral clock not the system bus clock at divide by one");
   chk_card_off: assert property (!gate_run[2] |=> !clocks.card_interface_clock)
      else $error("Card clock pulsed while gated off");
   chk_dma_off: assert property (!gate_run[4] |=> !clocks.dma_clock)
      else $error("DMA clock pulsed while gated off");
endmodule
`default_nettype wire

// file: pkg/pcg_defs.svh
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH
// Register byte addresses
`define PCG_OFF_MAIN 32'h0001EE00
`define PCG_OFF_CODEC 32'h0001EE04
`define PCG_OFF_SYS 32'h0001EE08
`define PCG_OFF_PERIPH 32'h0001EE0C
`define PCG_OFF_NDIV 32'h0001EE10
`define PCG_OFF_MDIV 32'h0001EE14
`define PCG_OFF_ODIV 32'h0001EE18
`define PCG_OFF_PDBP 32'h0001EE1C
`define PCG_OFF_TEST 32'h0001EE20
`define PCG_OFF_STATUS 32'h0001EE24
`define PCG_OFF_GATE 32'h0001EE38
// Reset values
`define PCG_RST_MAIN 16'h0001
`define PCG_RST_CODEC 16'h0107
`define PCG_RST_SYS 16'h0000
`define PCG_RST_PERIPH 16'h0000
`define PCG_RST_NDIV 16'h0006
`define PCG_RST_MDIV 16'h001E
`define PCG_RST_ODIV 16'h0000
`define PCG_RST_PDBP 16'h0001
`define PCG_RST_TEST 16'h0000
`define PCG_RST_GATE 16'h001F
// Field positions
`define PCG_BIT_CODEC_SEL 8
`define PCG_BIT_BYPASS 0
`define PCG_BIT_PDOWN 1
`define PCG_BIT_TEST_EN 0
`define PCG_BIT_AUX1_DIS 3
`define PCG_BIT_AUX2_DIS 4
`define PCG_GATE_USB 0
`define PCG_GATE_CODEC 1
`define PCG_GATE_CARD 2
`define PCG_GATE_MEM 3
`define PCG_GATE_DMA 4
// PLL ratio offset and clock limits in MHz
`define PCG_PLL_RATIO_OFFSET 2
`define PCG_REF_MHZ 24
`define PCG_FIXED_MHZ 12
`define PCG_PWM_MAX_MHZ 1
`define PCG_PWM_MIN_RATIO (`PCG_FIXED_MHZ / `PCG_PWM_MAX_MHZ - 1)
`endif

// file: pkg/pcg_pkg.sv
`default_nettype none
package pcg_pkg;
   // Controls driven into the analog PLL macro
   typedef struct packed {
      logic [4:0] input_ratio;
      logic [8:0] feedback_ratio;
      logic [5:0] input_ratio_eff;
      logic [9:0] feedback_ratio_eff;
      logic [1:0] pll_output_ratio;
      logic pll_bypass;
      logic pll_power_down;
      logic pll_reset;
      logic [1:0] pll_test_select;
      logic pll_aux_output_one_disable;
      logic pll_aux_output_two_disable;
   } pcg_pll_ctrl_s;
   // Derived clock waveforms
   typedef struct packed {
      logic main_clock;
      logic system_bus_clock;
      logic peripheral_bus_clock;
      logic codec_master_clock;
      logic usb_fixed_clock;
      logic card_interface_clock;
      logic dma_clock;
      logic memory_controller_clock;
      logic converter_clock;
      logic pwm_count_clock;
   } pcg_clocks_s;
endpackage
`default_nettype wire

// file: hdl/pcg_divider.sv
`default_nettype none
module pcg_divider #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic enable,
   input wire logic [W-1:0] ratio,
   output logic clk_level,
   output logic period_start,
   output logic running
);
   logic [W-1:0] cnt, cur, next_cnt, next_cur;
   logic next_run, next_level;

   // New period starts whenever an enabled tick meets a zero count
   assign period_start = tick && (cnt == '0) && enable;

   // Ratio and enable are only taken once the count reaches zero
   always_comb begin
      next_cnt = cnt;
      next_cur = cur;
      next_run = running;
      if (tick) begin
         if (cnt == '0) begin
            next_run = enable;
            next_cnt = enable ? ratio : '0;
            next_cur = enable ? ratio : cur;
         end else begin
            next_cnt = cnt - W'(1);
         end
      end
      if (next_cur == '0)
         next_level = next_run;
      else
         next_level = next_run && ({next_cnt, 1'b0} >= ({1'b0, next_cur} + (W+1)'(1)));
   end

   // Counter state and registered waveform
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         cur <= '0;
         running <= 1'b0;
         clk_level <= 1'b0;
      end else begin
         cnt <= next_cnt;
         cur <= next_cur;
         running <= next_run;
         clk_level <= next_level;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_ratio_held: assert property (!(tick && cnt == '0) |=> cur == $past(cur))
      else $error("Divider ratio changed mid period");
   chk_stop_at_end: assert property ($fell(running) |-> $past(cnt) == '0 && !clk_level)
      else $error("Divider stopped before period end");
endmodule
`default_nettype wire

// file: testbench/pcg_oscillator_model.sv
`default_nettype none
module pcg_oscillator_model (
   input wire logic core_clk,
   input wire logic rst_n,
   output logic ref_clk,
   output logic fixed_12m_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   int acc;
   logic flip;
   assign flip = (acc + 48 >= 250);
   ////////////////////////////////////////////////////////////////
   // Crystal as a 24 MHz level, phase accumulator on the core clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 0;
         ref_clk <= 1'b0;
      end else if (flip) begin
         acc <= acc + 48 - 250;
         ref_clk <= ~ref_clk;
      end else begin
         acc <= acc + 48;
      end
   end
   // Fixed 12 MHz level, crystal halved
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fixed_12m_clk <= 1'b0;
      end else if (flip && !ref_clk) begin
         fixed_12m_clk <= ~fixed_12m_clk;
      end
   end
endmodule
`default_nettype wire

// file: testbench/pcg_clock_generator_test.sv
`default_nettype none
`include "pcg_defs.svh"
module pcg_clock_generator_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [31:0] a; logic [15:0] r; logic [15:0] v;} pcg_row_s;
   logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, ref_clk, fixed_12m_clk, pll_ext_reset_n;
   logic [31:0] avs_address, avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [2:0] converter_ratio_select;
   logic [9:0] pwm_prescale_value;
   pcg_pkg::pcg_pll_ctrl_s pll_ctrl;
   pcg_pkg::pcg_clocks_s clocks, p;
   int miscompares, n_tests, cyc, e, bad;
   // Register table: address, reset value, readback after all ones
   pcg_row_s rows [11] = '{
      '{`PCG_OFF_MAIN, 16'h0001, 16'h00FF}, '{`PCG_OFF_CODEC, 16'h0107, 16'h01FF},
      '{`PCG_OFF_SYS, 16'h0000, 16'h0003}, '{`PCG_OFF_PERIPH, 16'h0000, 16'h0003},
      '{`PCG_OFF_NDIV, 16'h0006, 16'h001F}, '{`PCG_OFF_MDIV, 16'h001E, 16'h01FF},
      '{`PCG_OFF_ODIV, 16'h0000, 16'h0003}, '{`PCG_OFF_PDBP, 16'h0001, 16'h0003},
      '{`PCG_OFF_GATE, 16'h001F, 16'h001F}, '{`PCG_OFF_TEST, 16'h0000, 16'h001F},
      '{32'h0001EE30, 16'h0000, 16'h0000}};
   pcg_clock_generator dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ref_clk(ref_clk), .fixed_12m_clk(fixed_12m_clk), .pll_ext_reset_n(pll_ext_reset_n),
      .converter_ratio_select(converter_ratio_select), .pwm_prescale_value(pwm_prescale_value),
      .pll_ctrl(pll_ctrl), .clocks(clocks));
   pcg_oscillator_model osc (.core_clk(core_clk), .rst_n(rst_n), .ref_clk(ref_clk),
      .fixed_12m_clk(fixed_12m_clk));
   ////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic stop_test;
      if (miscompares == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Exact and ranged comparisons
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rng(input string n, input int lo, input int hi, input int g);
      n_tests++;
      if (g < lo || g > hi) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   // One Avalon transfer, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {16'h0000, d};
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge core_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   // Rising edges of one clock over a window
   task automatic edges(input int i, input int n);
      logic o;
      e = 0;
      @(negedge core_clk);
      o = clocks[i];
      repeat (n) begin
         @(negedge core_clk);
         if (clocks[i] === 1'b1 && o === 1'b0) e++;
         o = clocks[i];
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      rst_n <= 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} <= '0;
      avs_byteenable <= 4'hF;
      pll_ext_reset_n <= 1'b0;
      converter_ratio_select <= 3'h1;
      pwm_prescale_value <= 10'h000;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      foreach (rows[r]) begin
         bus(0, rows[r].a, 16'h0000);
         chk("reset_value", {16'h0000, rows[r].r}, q);
         bus(1, rows[r].a, 16'hFFFF);
         bus(0, rows[r].a, 16'h0000);
         chk("readback", {16'h0000, rows[r].v}, q);
      end
      // PLL controls from the register bank
      bus(1, `PCG_OFF_NDIV, 16'h000F);
      bus(1, `PCG_OFF_MDIV, 16'h007E);
      bus(1, `PCG_OFF_ODIV, 16'h0002);
      bus(1, `PCG_OFF_PDBP, 16'h0002);
      chk("n_eff", 32'h11, {26'h0, pll_ctrl.input_ratio_eff});
      chk("m_eff", 32'h80, {22'h0, pll_ctrl.feedback_ratio_eff});
      chk("m_field", 32'h7E, {23'h0, pll_ctrl.feedback_ratio});
      chk("od", 32'h2, {30'h0, pll_ctrl.pll_output_ratio});
      chk("pd_bp", 32'h2, {30'h0, pll_ctrl.pll_power_down, pll_ctrl.pll_bypass});
      bus(1, `PCG_OFF_TEST, 16'h0000);
      chk("pll_rst_norm", 32'h0, {31'h0, pll_ctrl.pll_reset});
      bus(1, `PCG_OFF_TEST, 16'h0001);
      chk("pll_rst_test", 32'h1, {31'h0, pll_ctrl.pll_reset});
      pll_ext_reset_n <= 1'b1;
      @(posedge core_clk);
      chk("pll_rst_ext", 32'h0, {31'h0, pll_ctrl.pll_reset});
      bus(1, `PCG_OFF_TEST, 16'h0000);
      // Dividers running from the PLL output, main period 4
      bus(1, `PCG_OFF_PDBP, 16'h0000);
      bus(1, `PCG_OFF_MAIN, 16'h0003);
      bus(1, `PCG_OFF_CODEC, 16'h0007);
      for (int k = 0; k < 4; k++) begin
         bus(1, `PCG_OFF_SYS, 16'(k));
         bus(1, `PCG_OFF_PERIPH, 16'(3 - k));
         repeat (400) @(posedge core_clk);
         edges(8, 512);
         chk("sys_edges", 128 >> k, e);
         edges(7, 512);
         chk("periph_edges", 16, e);
      end
      edges(9, 512);
      chk("main_edges", 128, e);
      edges(6, 512);
      chk("codec_edges", 64, e);
      bad = 0;
      p = clocks;
      repeat (512) begin
         @(negedge core_clk);
         if (clocks.peripheral_bus_clock && !p.peripheral_bus_clock &&
             !(clocks.main_clock && !p.main_clock && clocks.system_bus_clock && !p.system_bus_clock)) bad++;
         p = clocks;
      end
      chk("aligned", 0, bad);
      // Converter and count clocks from 12 MHz ticks
      edges(1, 1000);
      rng("converter", 23, 25, e);
      edges(0, 1000);
      rng("pwm_floor", 3, 5, e);
      pwm_prescale_value <= 10'h017;
      repeat (300) @(posedge core_clk);
      edges(0, 1000);
      rng("pwm_23", 1, 3, e);
      // Bypass: main from the reference
      bus(1, `PCG_OFF_PDBP, 16'h0001);
      bus(1, `PCG_OFF_MAIN, 16'h0001);
      repeat (100) @(posedge core_clk);
      edges(9, 1000);
      rng("bypass_main", 47, 49, e);
      // Gates off, then all gates back on and the card clock counted
      bus(1, `PCG_OFF_CODEC, 16'h0107);
      bus(1, `PCG_OFF_GATE, 16'h0000);
      repeat (400) @(posedge core_clk);
      for (int i = 2; i < 7; i++) begin
         edges(i, 400);
         chk("gated_off", 0, e);
      end
      bus(1, `PCG_OFF_GATE, 16'h001F);
      repeat (400) @(posedge core_clk);
      edges(4, 800);
      rng("card_on", 2, 6, e);
      bus(0, `PCG_OFF_STATUS, 16'h0000);
      chk("status", 32'h000007F7, q);
      // Second reset in mid-run
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("clocks_reset", 32'h0, {22'h0, clocks});
      rst_n <= 1'b1;
      @(posedge core_clk);
      bus(0, `PCG_OFF_MAIN, 16'h0000);
      chk("main_reset", 32'h1, q);
      stop_test();
   end
endmodule
`default_nettype wire
